// ==== core/lock_pkg.sv ====
// shared constants, types and helpers for lock forwarding
package lock_pkg;
   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int TIMER_W = 8;
   localparam logic [DATA_W-1:0] RDATA_MABORT = 32'hffffffff;
   localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
   localparam logic [TIMER_W-1:0] TIMER_RST = 8'h00;
   localparam logic [TIMER_W-1:0] TIMER_OFF = 8'h00;
   localparam logic [TIMER_W-1:0] TIMER_ONE = 8'h01;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      TERM_NONE = 3'b000,
      TERM_DONE = 3'b001,
      TERM_RETRY = 3'b010,
      TERM_TABORT = 3'b011,
      TERM_MABORT = 3'b100
   } term_t;

   typedef enum logic [2:0]
   {
      B_IDLE = 3'b000,
      B_ADDR = 3'b001,
      B_REQ = 3'b010,
      B_YADDR = 3'b011,
      B_YDATA = 3'b100,
      B_TERM = 3'b101
   } bst_t;

   typedef enum logic [1:0]
   {
      I_IDLE = 2'b00,
      I_ADDR = 2'b01,
      I_ADDR2 = 2'b10,
      I_DATA = 2'b11
   } ist_t;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic is_abort(input term_t t);
      is_abort = (t == TERM_TABORT) || (t == TERM_MABORT);
   endfunction : is_abort

   // a retry before the lock is owned, or any abort, ends the lock
   function automatic logic ends_lock(input term_t t, input logic owned);
      ends_lock = is_abort(t) || ((t == TERM_RETRY) && !owned);
   endfunction : ends_lock
endpackage : lock_pkg

// ==== core/lock_link_if.sv ====
// initiator bus and target bus signals between the bridge and the far parties
`timescale 1ns/1ps
interface lock_link_if;
   import lock_pkg::*;
   // initiator bus, driven by the initiator
   logic x_frame_n;
   logic x_irdy_n;
   logic x_lock_n;
   logic x_read;
   logic x_cross;
   // initiator bus, driven by the bridge
   term_t x_term;
   logic [DATA_W-1:0] x_rdata;
   // target bus, driven by the bridge
   logic y_req;
   logic y_frame_n;
   logic y_lock_n;
   logic y_read;
   // target bus, driven by arbiter, other masters and target
   logic y_gnt;
   logic y_lock_busy_n;
   term_t y_term;
   logic [DATA_W-1:0] y_rdata;

   modport bridge
   (
      input x_frame_n, x_irdy_n, x_lock_n, x_read, x_cross,
      output x_term, x_rdata,
      output y_req, y_frame_n, y_lock_n, y_read,
      input y_gnt, y_lock_busy_n, y_term, y_rdata
   );

   modport party
   (
      output x_frame_n, x_irdy_n, x_lock_n, x_read, x_cross,
      input x_term, x_rdata,
      input y_req, y_frame_n, y_lock_n, y_read,
      output y_gnt, y_lock_busy_n, y_term, y_rdata
   );
endinterface : lock_link_if

// ==== core/lock_wait_timer.sv ====
// target wait timer: counts while waiting for the target bus
`timescale 1ns/1ps
module lock_wait_timer
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_run,
   input wire logic [lock_pkg::TIMER_W-1:0] i_limit,
   output logic o_expired
);
   import lock_pkg::*;

   logic [TIMER_W-1:0] cnt_r;
   logic [TIMER_W-1:0] cnt_nxt;
   logic expired_nxt;
   wire at_top = (cnt_r == {TIMER_W{1'b1}});

   assign cnt_nxt = !i_run ? TIMER_RST : (at_top ? cnt_r : cnt_r + TIMER_ONE);
   // zero limit disables the timer
   assign expired_nxt = i_run && (i_limit != TIMER_OFF) && (cnt_nxt >= i_limit);

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_r <= TIMER_RST;
         o_expired <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         o_expired <= expired_nxt;
      end
   end
endmodule : lock_wait_timer

// ==== core/lock_bridge.sv ====
// bridge end: acquires, holds and releases the target bus lock
`timescale 1ns/1ps
module lock_bridge
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_fwd_busy,
   input wire logic i_mabort_tabort,
   input wire logic [lock_pkg::TIMER_W-1:0] i_wait_limit,
   lock_link_if.bridge lnk,
   output logic o_lock_held,
   output logic o_post_allow
);
   import lock_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   bst_t st_r;
   bst_t st_nxt;
   logic held_r;
   logic held_nxt;
   logic locked_r;
   logic locked_nxt;
   logic addr_free_r;
   logic addr_free_nxt;
   logic read_r;
   logic read_nxt;
   term_t xterm_r;
   term_t xterm_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic yreq_r;
   logic yframe_n_r;
   logic ylock_n_r;
   logic post_r;
   logic tmo;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire x_idle = lnk.x_frame_n && lnk.x_irdy_n;
   // only transactions that cross toward the far bus are tracked
   wire x_start = (st_r == B_IDLE) && !lnk.x_frame_n && lnk.x_cross;
   // lock high at address, low one phase later
   wire lock_txn = addr_free_r && !lnk.x_lock_n;
   // another master owns the target bus lock
   wire y_taken = !held_r && !lnk.y_lock_busy_n;
   wire acq_refuse = lock_txn && !held_r && (i_fwd_busy || y_taken);
   wire release_req = held_r && (st_r == B_IDLE) && lnk.x_lock_n && x_idle;
   wire y_answer = (st_r == B_YDATA) && (lnk.y_term != TERM_NONE);
   wire y_drop = y_answer && locked_r && ends_lock(lnk.y_term, held_r);
   wire y_gain = y_answer && locked_r && (lnk.y_term == TERM_DONE);
   wire y_mabort = (lnk.y_term == TERM_MABORT);
   // master abort mapped by mode, others returned as they came
   wire term_t mab_term = i_mabort_tabort ? TERM_TABORT : TERM_DONE;
   wire term_t ret_term = y_mabort ? mab_term : lnk.y_term;
   wire [DATA_W-1:0] ret_data = y_mabort ? RDATA_MABORT : lnk.y_rdata;
   wire in_req = (st_r == B_REQ);

   // ---------------------------------------------------------------
   // target wait timer
   // ---------------------------------------------------------------
   lock_wait_timer u_wait
   (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_run(in_req),
      .i_limit(i_wait_limit),
      .o_expired(tmo)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      held_nxt = held_r;
      locked_nxt = locked_r;
      addr_free_nxt = addr_free_r;
      read_nxt = read_r;
      xterm_nxt = TERM_NONE;
      rdata_nxt = rdata_r;
      case (st_r)
         B_IDLE:
         begin
            if (release_req)
            begin
               held_nxt = 1'b0;
            end
            if (x_start)
            begin
               st_nxt = B_ADDR;
               addr_free_nxt = lnk.x_lock_n;
               read_nxt = lnk.x_read;
            end
         end
         B_ADDR:
         begin
            locked_nxt = lock_txn;
            if (acq_refuse)
            begin
               xterm_nxt = TERM_RETRY;
               st_nxt = B_TERM;
            end
            else
            begin
               st_nxt = B_REQ;
            end
         end
         B_REQ:
         begin
            if (lnk.y_gnt)
            begin
               st_nxt = B_YADDR;
            end
            else if (tmo)
            begin
               xterm_nxt = TERM_RETRY;
               st_nxt = B_TERM;
            end
         end
         B_YADDR:
         begin
            st_nxt = B_YDATA;
         end
         B_YDATA:
         begin
            // every transaction waits for the target, so aborts reach back
            if (y_answer)
            begin
               st_nxt = B_TERM;
               xterm_nxt = ret_term;
               rdata_nxt = ret_data;
               if (y_drop)
               begin
                  held_nxt = 1'b0;
               end
               else if (y_gain)
               begin
                  held_nxt = 1'b1;
               end
            end
         end
         B_TERM:
         begin
            st_nxt = B_IDLE;
         end
         default:
         begin
            st_nxt = B_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // target bus outputs
   // ---------------------------------------------------------------
   wire yreq_nxt = (st_nxt == B_REQ) || (st_nxt == B_YADDR) || (st_nxt == B_YDATA);
   wire yframe_n_nxt = (st_nxt != B_YADDR);
   // lock free during address, asserted from the next cycle
   wire ylock_nxt = (locked_nxt && (st_nxt == B_YDATA)) ||
                    (held_nxt && !(locked_nxt && (st_nxt == B_YADDR)));
   wire post_nxt = !ylock_nxt && !held_nxt;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st_r <= B_IDLE;
         held_r <= 1'b0;
         locked_r <= 1'b0;
         addr_free_r <= 1'b0;
         read_r <= 1'b0;
         xterm_r <= TERM_NONE;
         rdata_r <= RDATA_RST;
      end
      else
      begin
         st_r <= st_nxt;
         held_r <= held_nxt;
         locked_r <= locked_nxt;
         addr_free_r <= addr_free_nxt;
         read_r <= read_nxt;
         xterm_r <= xterm_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         yreq_r <= 1'b0;
         yframe_n_r <= 1'b1;
         ylock_n_r <= 1'b1;
         post_r <= 1'b1;
         o_lock_held <= 1'b0;
      end
      else
      begin
         yreq_r <= yreq_nxt;
         yframe_n_r <= yframe_n_nxt;
         ylock_n_r <= !ylock_nxt;
         post_r <= post_nxt;
         o_lock_held <= held_nxt;
      end
   end

   assign o_post_allow = post_r;
   assign lnk.x_term = xterm_r;
   assign lnk.x_rdata = rdata_r;
   assign lnk.y_req = yreq_r;
   assign lnk.y_frame_n = yframe_n_r;
   assign lnk.y_lock_n = ylock_n_r;
   assign lnk.y_read = read_r;
endmodule : lock_bridge

// ==== core/lock_party.sv ====
// far end: locking initiator on one bus, arbiter and target on the other
`timescale 1ns/1ps
module lock_party
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_go,
   input wire logic i_read,
   input wire logic i_lock,
   input wire logic i_dac,
   input wire logic i_cross,
   input wire logic i_unlock,
   input wire logic i_gnt,
   input wire logic i_other_lock,
   input wire lock_pkg::term_t i_tgt_term,
   input wire logic [lock_pkg::DATA_W-1:0] i_tgt_rdata,
   lock_link_if.party lnk,
   output logic o_busy,
   output logic o_owner,
   output logic o_done,
   output lock_pkg::term_t o_term,
   output logic [lock_pkg::DATA_W-1:0] o_rdata
);
   import lock_pkg::*;

   // ---------------------------------------------------------------
   // initiator
   // ---------------------------------------------------------------
   ist_t st_r;
   ist_t st_nxt;
   logic own_r;
   logic own_nxt;
   logic lk_r;
   logic lk_nxt;
   logic dac_r;
   logic read_r;
   logic cross_r;
   logic frame_n_r;
   logic irdy_n_r;
   logic lock_n_r;
   term_t yterm_r;
   logic [DATA_W-1:0] yrdata_r;
   logic gnt_r;
   logic busy_n_r;

   wire answered = (st_r == I_DATA) && (lnk.x_term != TERM_NONE);

   always_comb
   begin
      st_nxt = st_r;
      own_nxt = own_r;
      lk_nxt = lk_r;
      case (st_r)
         I_IDLE:
         begin
            if (i_go)
            begin
               st_nxt = I_ADDR;
               // a lock is opened only by a read
               lk_nxt = i_lock && (own_r || i_read);
            end
            else if (own_r && i_unlock)
            begin
               own_nxt = 1'b0;
            end
         end
         I_ADDR:
         begin
            st_nxt = dac_r ? I_ADDR2 : I_DATA;
         end
         I_ADDR2:
         begin
            st_nxt = I_DATA;
         end
         I_DATA:
         begin
            if (answered)
            begin
               st_nxt = I_IDLE;
               if (lk_r && ends_lock(lnk.x_term, own_r))
               begin
                  own_nxt = 1'b0;
               end
               else if (lk_r && (lnk.x_term == TERM_DONE))
               begin
                  own_nxt = 1'b1;
               end
            end
         end
         default:
         begin
            st_nxt = I_IDLE;
         end
      endcase
   end

   wire frame_nxt = (st_nxt == I_ADDR) || (st_nxt == I_ADDR2);
   // free in the first address phase, asserted from the next one
   wire lock_nxt = (lk_nxt && ((st_nxt == I_ADDR2) || (st_nxt == I_DATA))) ||
                   (own_nxt && !(lk_nxt && (st_nxt == I_ADDR)));
   wire term_t tgt_ans = (i_tgt_term == TERM_NONE) ? TERM_MABORT : i_tgt_term;

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st_r <= I_IDLE;
         own_r <= 1'b0;
         lk_r <= 1'b0;
         dac_r <= 1'b0;
         read_r <= 1'b0;
         cross_r <= 1'b0;
         frame_n_r <= 1'b1;
         irdy_n_r <= 1'b1;
         lock_n_r <= 1'b1;
         o_busy <= 1'b0;
         o_owner <= 1'b0;
         o_done <= 1'b0;
         o_term <= TERM_NONE;
         o_rdata <= RDATA_RST;
      end
      else
      begin
         st_r <= st_nxt;
         own_r <= own_nxt;
         lk_r <= lk_nxt;
         if (i_go && (st_r == I_IDLE))
         begin
            dac_r <= i_dac;
            read_r <= i_read;
            cross_r <= i_cross;
         end
         frame_n_r <= !frame_nxt;
         irdy_n_r <= (st_nxt != I_DATA);
         lock_n_r <= !lock_nxt;
         o_busy <= (st_nxt != I_IDLE);
         o_owner <= own_nxt;
         o_done <= answered;
         if (answered)
         begin
            o_term <= lnk.x_term;
            o_rdata <= lnk.x_rdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // target bus: arbiter, other lock masters, target
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         yterm_r <= TERM_NONE;
         yrdata_r <= RDATA_RST;
         gnt_r <= 1'b0;
         busy_n_r <= 1'b1;
      end
      else
      begin
         yterm_r <= !lnk.y_frame_n ? tgt_ans : TERM_NONE;
         yrdata_r <= i_tgt_rdata;
         gnt_r <= i_gnt && lnk.y_req;
         busy_n_r <= !i_other_lock;
      end
   end

   assign lnk.x_frame_n = frame_n_r;
   assign lnk.x_irdy_n = irdy_n_r;
   assign lnk.x_lock_n = lock_n_r;
   assign lnk.x_read = read_r;
   assign lnk.x_cross = cross_r;
   assign lnk.y_gnt = gnt_r;
   assign lnk.y_lock_busy_n = busy_n_r;
   assign lnk.y_term = yterm_r;
   assign lnk.y_rdata = yrdata_r;
endmodule : lock_party

// ==== dv/lock_bridge_chk.sv ====
// assertions on the link between bridge end and far end
`timescale 1ns/1ps
module lock_bridge_chk
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic x_frame_n,
   input wire logic x_lock_n,
   input wire logic x_cross,
   input wire logic x_read,
   input wire lock_pkg::term_t x_term,
   input wire logic [lock_pkg::DATA_W-1:0] x_rdata,
   input wire logic y_req,
   input wire logic y_frame_n,
   input wire logic y_read,
   input wire logic y_lock_n,
   input wire logic y_gnt,
   input wire logic y_lock_busy_n,
   input wire lock_pkg::term_t y_term
);
   import lock_pkg::*;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   rst_idle_a: assert property (!$past(i_nrst) |-> y_lock_n && !y_req && y_frame_n)
      else $error("target lock or request active after reset");
   addr_unlock_a: assert property (!y_frame_n |-> y_lock_n && $past(y_gnt))
      else $error("target address without grant or with lock low");
   read_fwd_a: assert property (!y_frame_n |-> y_read == x_read)
      else $error("forwarded direction differs from initiator");
   lock_after_addr_a: assert property ($fell(y_lock_n) |-> !$past(y_frame_n) && !x_lock_n)
      else $error("target lock taken outside a locked address");
   busy_retry_a: assert property (!x_frame_n && x_cross && x_lock_n && y_lock_n &&
      !y_lock_busy_n ##1 !x_lock_n && !y_lock_busy_n |=> x_term == TERM_RETRY && !y_req)
      else $error("busy target lock not answered by retry");
   mabort_map_a: assert property (y_term == TERM_MABORT |=> x_term == TERM_TABORT ||
      (x_term == TERM_DONE && x_rdata == RDATA_MABORT))
      else $error("master abort mapped wrongly");
   term_pass_a: assert property (y_term inside {TERM_RETRY, TERM_TABORT}
      |=> x_term == $past(y_term))
      else $error("target termination not passed back");
   abort_free_a: assert property (y_term inside {TERM_TABORT, TERM_MABORT}
      |-> ##[1:3] y_lock_n)
      else $error("target lock kept after abort");
   release_a: assert property ($rose(x_lock_n) && x_frame_n |-> ##[0:2] y_lock_n)
      else $error("target lock not released in two cycles");
   hold_a: assert property ($rose(y_lock_n) |-> !y_frame_n || x_lock_n || $past(x_lock_n)
      || $past(x_lock_n, 2) || $past(y_term) != TERM_NONE || $past(y_term, 2) != TERM_NONE
      || $past(y_term, 3) != TERM_NONE)
      else $error("target lock dropped without cause");
endmodule : lock_bridge_chk

// ==== dv/pci_bridge_lock_forwarding_tb.sv ====
// bench: bridge end and far end joined, locked sequences driven
`timescale 1ns/1ps
module pci_bridge_lock_forwarding_tb;
   import lock_pkg::*;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic i_fwd_busy = 1'b0;
   logic i_mabort_tabort = 1'b0;
   logic [TIMER_W-1:0] i_wait_limit = TIMER_OFF;
   logic i_go = 1'b0;
   logic i_read = 1'b0;
   logic i_lock = 1'b0;
   logic i_unlock = 1'b0;
   logic i_dac = 1'b0;
   logic i_cross = 1'b1;
   logic i_gnt = 1'b1;
   logic i_other_lock = 1'b0;
   term_t i_tgt_term = TERM_DONE;
   logic [DATA_W-1:0] i_tgt_rdata = RDATA_RST;
   logic held, post, busy, owner, done;
   term_t res_term;
   logic [DATA_W-1:0] res_data;
   int error_cnt = 0;
   int comparisons = 0;
   term_t tt [4] = '{TERM_RETRY, TERM_TABORT, TERM_MABORT, TERM_MABORT};
   term_t et [4] = '{TERM_RETRY, TERM_TABORT, TERM_DONE, TERM_TABORT};

   always #10 i_clock = ~i_clock;

   lock_link_if lnk ();
   lock_bridge i_lock_bridge
   (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_fwd_busy(i_fwd_busy),
      .i_mabort_tabort(i_mabort_tabort), .i_wait_limit(i_wait_limit), .lnk(lnk.bridge),
      .o_lock_held(held), .o_post_allow(post)
   );
   lock_party i_lock_party
   (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_go(i_go), .i_read(i_read), .i_lock(i_lock),
      .i_dac(i_dac), .i_cross(i_cross), .i_unlock(i_unlock), .i_gnt(i_gnt),
      .i_other_lock(i_other_lock), .i_tgt_term(i_tgt_term), .i_tgt_rdata(i_tgt_rdata),
      .lnk(lnk.party), .o_busy(busy), .o_owner(owner), .o_done(done), .o_term(res_term),
      .o_rdata(res_data)
   );
   lock_bridge_chk i_lock_bridge_chk
   (
      .i_clock(i_clock), .i_nrst(i_nrst), .x_frame_n(lnk.x_frame_n), .x_lock_n(lnk.x_lock_n),
      .x_cross(lnk.x_cross), .x_term(lnk.x_term), .x_rdata(lnk.x_rdata), .y_req(lnk.y_req),
      .y_frame_n(lnk.y_frame_n), .y_lock_n(lnk.y_lock_n), .y_gnt(lnk.y_gnt),
      .y_lock_busy_n(lnk.y_lock_busy_n), .y_term(lnk.y_term),
      .x_read(lnk.x_read), .y_read(lnk.y_read)
   );

   // ------
   // tasks
   // ------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic start(input logic rd, input logic lk, input term_t t, input logic [31:0] d);
      @(negedge i_clock);
      i_read = rd;
      i_lock = lk;
      i_tgt_term = t;
      i_tgt_rdata = d;
      i_go = 1'b1;
      @(negedge i_clock);
      i_go = 1'b0;
   endtask : start

   task automatic finish(input term_t t, input logic [31:0] d, input logic h);
      int n;
      n = 0;
      while (done !== 1'b1 && n < 400)
      begin
         @(negedge i_clock);
         n++;
      end
      chk("done", 32'h1, {31'h0, done});
      chk("term", 32'(t), 32'(res_term));
      if (t == TERM_DONE)
         chk("rdata", d, res_data);
      chk("held", {31'h0, h}, {31'h0, held});
      chk("post", {31'h0, !h}, {31'h0, post});
   endtask : finish

   task automatic free_lock;
      i_unlock = 1'b1;
      repeat (4) @(negedge i_clock);
      chk("released", 32'h1, {31'h0, lnk.y_lock_n});
      chk("owner", 32'h0, {31'h0, owner});
      i_unlock = 1'b0;
   endtask : free_lock

   task automatic print_verdict;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   // ------
   // tests
   // ------
   initial
   begin
      repeat (12) @(negedge i_clock);
      chk("reset lock", 32'h1, {31'h0, lnk.y_lock_n});
      i_nrst = 1'b1;
      @(negedge i_clock);
      chk("idle held", 32'h0, {31'h0, held});
      start(1'b1, 1'b1, TERM_DONE, 32'h5a5a0001);
      finish(TERM_DONE, 32'h5a5a0001, 1'b1);
      chk("owner", 32'h1, {31'h0, owner});
      start(1'b0, 1'b1, TERM_DONE, 32'h0);
      finish(TERM_DONE, 32'h0, 1'b1);
      free_lock();
      for (int k = 0; k < 4; k++)
      begin
         i_mabort_tabort = (k == 3);
         start(1'b1, 1'b1, tt[k], 32'h0000_00a5);
         finish(et[k], RDATA_MABORT, 1'b0);
         free_lock();
      end
      i_mabort_tabort = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         i_other_lock = (k == 0);
         i_fwd_busy = (k == 1);
         i_gnt = (k != 2);
         i_wait_limit = 8'h04;
         repeat (3) @(negedge i_clock);
         start(1'b1, 1'b1, TERM_DONE, 32'h0);
         finish(TERM_RETRY, 32'h0, 1'b0);
         free_lock();
      end
      i_other_lock = 1'b0;
      i_fwd_busy = 1'b0;
      i_wait_limit = TIMER_OFF;
      start(1'b1, 1'b1, TERM_DONE, 32'h1234_5678);
      repeat (30) @(negedge i_clock);
      chk("still busy", 32'h1, {31'h0, busy});
      i_gnt = 1'b1;
      finish(TERM_DONE, 32'h1234_5678, 1'b1);
      free_lock();
      i_dac = 1'b1;
      start(1'b1, 1'b1, TERM_DONE, 32'h0dac_0001);
      finish(TERM_DONE, 32'h0dac_0001, 1'b1);
      free_lock();
      i_dac = 1'b0;
      start(1'b0, 1'b1, TERM_DONE, 32'h0);
      finish(TERM_DONE, 32'h0, 1'b0);
      start(1'b0, 1'b0, TERM_DONE, 32'h0);
      finish(TERM_DONE, 32'h0, 1'b0);
      i_cross = 1'b0;
      start(1'b1, 1'b1, TERM_DONE, 32'h0);
      repeat (10) @(negedge i_clock);
      chk("ignored req", 32'h0, {31'h0, lnk.y_req});
      chk("ignored busy", 32'h1, {31'h0, busy});
      i_nrst = 1'b0;
      @(negedge i_clock);
      i_nrst = 1'b1;
      i_cross = 1'b1;
      @(negedge i_clock);
      chk("reset owner", 32'h0, {31'h0, owner});
      chk("reset busy", 32'h0, {31'h0, busy});
      chk("reset held", 32'h0, {31'h0, held});
      start(1'b1, 1'b1, TERM_DONE, 32'h0000_0c3c);
      finish(TERM_DONE, 32'h0000_0c3c, 1'b1);
      free_lock();
      print_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge i_clock);
      error_cnt++;
      print_verdict();
   end
endmodule : pci_bridge_lock_forwarding_tb
